/* File: ebamc_seq.sv */
// Purpose: Cycle sequencer for the asynchronous multiplexed expansion bus.
// Assumes: Inputs synchronous to clk; config stable while busy is low.
// Notes:   Outputs are registered from the next state, so each pin
//          changes in the same cycle as the state it belongs to.
`timescale 1ns/1ps
module ebamc_seq
    import ebamc_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start,
    input wire ebamc_req_t req,
    input wire ebamc_cfg_t cfg,
    input wire logic [AD_W-1:0] ad_in,
    output logic [AD_W-1:0] ad_out,
    output logic ad_oe,
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [AD_W-1:0] rdata,
    output logic busy,
    output logic done
);
    ebamc_state_t state;
    ebamc_state_t next_state;
    ebamc_req_t req_q;
    ebamc_req_t next_req;
    ebamc_cfg_t cfg_q;
    ebamc_cfg_t next_cfg;
    logic tmr_last;
    logic tmr_load;
    logic [CNT_W-1:0] tmr_val;
    logic [AGE_W-1:0] age;
    logic rstn_q;
    logic chk_off;

    // Timer load value for a phase, length minus one
    function automatic logic [CNT_W-1:0] phase_cnt(
        input ebamc_state_t st,
        input ebamc_cfg_t c
    );
        case (st)
            EBAMC_ADDR: phase_cnt = {2'h0, c.addr_phase_len};
            EBAMC_AHOLD: phase_cnt = AHOLD_CNT;
            EBAMC_SETUP: phase_cnt = {2'h0, c.setup_phase_len};
            EBAMC_STROBE: phase_cnt = c.strobe_phase_len;
            EBAMC_HOLD: phase_cnt = {2'h0, c.hold_phase_len};
            EBAMC_RECOV: phase_cnt = c.recovery_phase_len;
            default: phase_cnt = CNT_ZERO;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            EBAMC_IDLE: begin
                if (start) begin
                    next_state = EBAMC_ADDR;
                end
            end
            EBAMC_ADDR: begin
                if (tmr_last) begin
                    next_state = EBAMC_AHOLD;
                end
            end
            EBAMC_AHOLD: begin
                if (tmr_last) begin
                    next_state = EBAMC_SETUP;
                end
            end
            EBAMC_SETUP: begin
                if (tmr_last) begin
                    next_state = EBAMC_STROBE;
                end
            end
            EBAMC_STROBE: begin
                if (tmr_last) begin
                    next_state = EBAMC_HOLD;
                end
            end
            EBAMC_HOLD: begin
                if (tmr_last) begin
                    next_state = EBAMC_RECOV;
                end
            end
            EBAMC_RECOV: begin
                if (tmr_last) begin
                    next_state = EBAMC_IDLE;
                end
            end
            default: next_state = EBAMC_IDLE;
        endcase
    end

    // A new request and its settings are only sampled from idle
    always_comb begin
        next_req = req_q;
        next_cfg = cfg_q;
        if (state == EBAMC_IDLE && start) begin
            next_req = req;
            next_cfg = cfg;
        end
    end

    assign tmr_load = (state == EBAMC_IDLE) || tmr_last;
    assign tmr_val = phase_cnt(next_state, next_cfg);

    ebamc_timer #(.W(CNT_W)) u_timer (
        .clk(clk),
        .rstn(rstn),
        .load(tmr_load),
        .load_val(tmr_val),
        .last(tmr_last)
    );

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= EBAMC_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            req_q <= '0;
            cfg_q <= '0;
        end else begin
            req_q <= next_req;
            cfg_q <= next_cfg;
        end
    end

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ale <= 1'b0;
            cs_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else begin
            ale <= (next_state == EBAMC_ADDR);
            cs_n <= !(next_state == EBAMC_SETUP ||
                      next_state == EBAMC_STROBE ||
                      next_state == EBAMC_HOLD);
            rd_n <= !(next_state == EBAMC_STROBE && !next_req.write);
            wr_n <= !(next_state == EBAMC_STROBE && next_req.write);
        end
    end

    // Lines are released for reads so the peripheral can drive them
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ad_oe <= 1'b0;
            ad_out <= '0;
        end else if (next_state == EBAMC_ADDR ||
                     next_state == EBAMC_AHOLD) begin
            ad_oe <= 1'b1;
            ad_out <= next_req.addr;
        end else if (next_req.write && (next_state == EBAMC_SETUP ||
                     next_state == EBAMC_STROBE ||
                     next_state == EBAMC_HOLD)) begin
            ad_oe <= 1'b1;
            ad_out <= next_req.wdata;
        end else begin
            ad_oe <= 1'b0;
            ad_out <= '0;
        end
    end

    // Read data is taken at the end of the strobe, the latest safe point
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata <= '0;
        end else if (state == EBAMC_STROBE && tmr_last && !req_q.write) begin
            rdata <= ad_in;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            busy <= (next_state != EBAMC_IDLE);
            done <= (state == EBAMC_HOLD && next_state == EBAMC_RECOV);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Cycles spent so far in the current phase, for the checks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            age <= 5'h01;
        end else if (next_state != state) begin
            age <= 5'h01;
        end else if (age != AGE_MAX) begin
            age <= age + 5'h01;
        end
    end

    // Checks stay off for one cycle after reset: a reset in mid access
    // steps the pins to idle, which would otherwise look like a phase edge
    always_ff @(posedge clk) begin
        rstn_q <= rstn;
    end

    assign chk_off = !rstn || !rstn_q;

    ale_addr_valid_a: assert property (@(posedge clk) disable iff (chk_off)
        $rose(ale) |-> ad_oe && ad_out == req_q.addr)
        else $error("address not valid at latch rise");

    ale_width_a: assert property (@(posedge clk) disable iff (chk_off)
        $fell(ale) |-> $past(age) == {3'h0, cfg_q.addr_phase_len} + 5'h01)
        else $error("latch strobe width wrong");

    addr_hold_a: assert property (@(posedge clk) disable iff (chk_off)
        $fell(ale) |-> ad_oe && ad_out == req_q.addr && cs_n
        ##1 !cs_n)
        else $error("address hold after latch wrong");

    select_delay_a: assert property (@(posedge clk) disable iff (chk_off)
        $fell(ale) |-> cs_n ##1 !cs_n)
        else $error("select not asserted one cycle after latch");

    write_setup_a: assert property (@(posedge clk) disable iff (chk_off)
        $fell(wr_n) |-> $past(ad_out) == req_q.wdata && $past(ad_oe) &&
        $past(age) == {3'h0, cfg_q.setup_phase_len} + 5'h01)
        else $error("write data setup wrong");

    strobe_width_a: assert property (@(posedge clk) disable iff (chk_off)
        ($rose(wr_n) || $rose(rd_n)) |->
        $past(age) == {1'b0, cfg_q.strobe_phase_len} + 5'h01)
        else $error("strobe width wrong");

    strobe_data_a: assert property (@(posedge clk) disable iff (chk_off)
        !wr_n |-> ad_oe && ad_out == req_q.wdata && !cs_n)
        else $error("data lost during write strobe");

    write_hold_a: assert property (@(posedge clk) disable iff (chk_off)
        $rose(wr_n) |-> !cs_n && ad_oe && ad_out == req_q.wdata)
        else $error("write hold lost");

    hold_width_a: assert property (@(posedge clk) disable iff (chk_off)
        $rose(cs_n) |->
        $past(age) == {3'h0, cfg_q.hold_phase_len} + 5'h01)
        else $error("hold phase width wrong");

    recov_gap_a: assert property (@(posedge clk) disable iff (chk_off)
        $rose(cs_n) |-> !ale && !ad_oe && rd_n && wr_n)
        else $error("bus not idle in recovery");

    recov_len_a: assert property (@(posedge clk) disable iff (chk_off)
        (state == EBAMC_RECOV && next_state != EBAMC_RECOV) |->
        age == {1'b0, cfg_q.recovery_phase_len} + 5'h01)
        else $error("recovery length wrong");

    phase_order_a: assert property (@(posedge clk) disable iff (chk_off)
        (state == EBAMC_SETUP && next_state != state) |->
        next_state == EBAMC_STROBE ##1 state == EBAMC_STROBE)
        else $error("phase order broken");
endmodule

/* File: ebamc_pkg.sv */
// Purpose: Shared constants and carriers for the multiplexed expansion
//          cycle sequencer.
// Assumes: One clock, synchronous active-low reset.
// Notes:   Phase fields hold the length minus one.
package ebamc_pkg;

    localparam int AD_W = 16;
    localparam int CNT_W = 4;
    localparam int AGE_W = 5;
    localparam logic [AGE_W-1:0] AGE_MAX = 5'h1f;
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    // Address hold after the latch strobe is fixed at one cycle
    localparam logic [CNT_W-1:0] AHOLD_CNT = 4'h0;

    typedef enum logic [2:0] {
        EBAMC_IDLE,
        EBAMC_ADDR,
        EBAMC_AHOLD,
        EBAMC_SETUP,
        EBAMC_STROBE,
        EBAMC_HOLD,
        EBAMC_RECOV
    } ebamc_state_t;

    // Each field is phase length minus one
    typedef struct packed {
        logic [1:0] addr_phase_len;
        logic [1:0] setup_phase_len;
        logic [3:0] strobe_phase_len;
        logic [1:0] hold_phase_len;
        logic [3:0] recovery_phase_len;
    } ebamc_cfg_t;

    typedef struct packed {
        logic write;
        logic [AD_W-1:0] addr;
        logic [AD_W-1:0] wdata;
    } ebamc_req_t;

endpackage

/* File: ebamc_timer.sv */
// Purpose: Down counter that measures one phase of the access.
// Assumes: Loaded with length minus one.
// Notes:   last is high in the final cycle of a phase.
`timescale 1ns/1ps
module ebamc_timer
    import ebamc_pkg::*;
#(
    parameter int W = CNT_W
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    output logic last
);
    logic [W-1:0] cnt;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cnt <= '0;
        end else if (load) begin
            cnt <= load_val;
        end else if (cnt != '0) begin
            cnt <= cnt - W'(1);
        end
    end

    assign last = (cnt == '0);
endmodule

/* File: ebamc_periph.sv */
// Purpose: Behavioural peripheral on the far side of the shared lines.
// Assumes: Address is latched while the latch strobe is high.
// Notes:   Read data is the latched address xor 16'h3c3c.
`timescale 1ns/1ps
module ebamc_periph
    import ebamc_pkg::*;
(
    input wire logic clk,
    input wire logic [AD_W-1:0] ad_out,
    input wire logic ad_oe,
    input wire logic ale,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [AD_W-1:0] ad_in,
    output logic [AD_W-1:0] got_addr,
    output logic [AD_W-1:0] got_wdata
);
    // ----------------------------------------
    // Shared line level
    // ----------------------------------------
    logic [AD_W-1:0] prev = 16'h0000;

    initial got_addr = 16'h0000;
    initial got_wdata = 16'h0000;
    // Undriven lines toggle so a stale value never reads as valid
    assign ad_in = ad_oe ? ad_out :
                   (!cs_n && !rd_n) ? (got_addr ^ 16'h3c3c) : ~prev;
    always @(posedge clk) prev <= ad_in;
    always @(posedge clk) if (ale) got_addr <= ad_out;
    always @(posedge clk) if (!cs_n && !wr_n) got_wdata <= ad_out;
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the multiplexed cycle sequencer.
// Assumes: Phase lengths are encoded as length minus one.
// Notes:   Each access is classified cycle by cycle at the falling edge.
`timescale 1ns/1ps
module testbench;
    import ebamc_pkg::*;
    typedef struct packed {
        logic write;
        logic [15:0] addr;
        logic [15:0] wdata;
        logic [15:0] exp_data;
        ebamc_cfg_t cfg;
    } ebamc_row_t;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic start = 1'b0;
    ebamc_req_t req = '0;
    ebamc_cfg_t cfg = '0;
    logic [AD_W-1:0] ad_in, ad_out, rdata, got_addr, got_wdata;
    logic ad_oe, ale, cs_n, rd_n, wr_n, busy, done;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    ebamc_row_t rows [6];

    always #2 clk = ~clk;
    ebamc_seq dut (.clk(clk), .rstn(rstn), .start(start), .req(req),
        .cfg(cfg), .ad_in(ad_in), .ad_out(ad_out), .ad_oe(ad_oe),
        .ale(ale), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .rdata(rdata),
        .busy(busy), .done(done));
    ebamc_periph p (.clk(clk), .ad_out(ad_out), .ad_oe(ad_oe), .ale(ale),
        .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .ad_in(ad_in),
        .got_addr(got_addr), .got_wdata(got_wdata));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic check(string name, logic [15:0] exp, logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic idle_chk();
        check("idle", 16'h0007, {9'h0, ale, ad_oe, busy, done, cs_n,
            rd_n, wr_n});
        check("ad_out", 16'h0000, ad_out);
    endtask

    task automatic run(ebamc_row_t r);
        int na = 0;
        int nah = 0;
        int ns = 0;
        int nw = 0;
        int nh = 0;
        int nr = 0;
        int k = 0;
        logic cs_seen = 1'b0;
        logic st_seen = 1'b0;
        @(posedge clk);
        req <= {r.write, r.addr, r.wdata};
        cfg <= r.cfg;
        start <= 1'b1;
        @(posedge clk);
        @(negedge clk);
        while (busy && k < 80) begin
            if (ale) begin
                na++;
                check("addr_lat", r.addr, ad_out);
            end else if (!cs_seen && cs_n) begin
                nah++;
                check("addr_hold", r.addr, ad_out);
            end else if (!cs_n) begin
                cs_seen = 1'b1;
                if (!rd_n || !wr_n) begin
                    nw++;
                    st_seen = 1'b1;
                    check("strobe", {14'h0, !r.write, r.write}, {14'h0, wr_n,
                        rd_n});
                end else if (st_seen) nh++;
                else ns++;
                check("oe", {15'h0, r.write}, {15'h0, ad_oe});
                if (r.write) check("wdata", r.wdata, ad_out);
            end else begin
                nr++;
                if (nr == 1) check("done", 16'h1, {15'h0, done});
            end
            @(posedge clk);
            if (k == 0) begin
                start <= 1'b0;
                req <= ~{r.write, r.addr, r.wdata};
                cfg <= ~r.cfg;
            end
            k++;
            @(negedge clk);
        end
        check("n_addr", 16'(r.cfg.addr_phase_len) + 16'h1, na[15:0]);
        check("n_ahold", 16'h1, nah[15:0]);
        check("n_setup", 16'(r.cfg.setup_phase_len) + 16'h1, ns[15:0]);
        check("n_strobe", 16'(r.cfg.strobe_phase_len) + 16'h1, nw[15:0]);
        check("n_hold", 16'(r.cfg.hold_phase_len) + 16'h1, nh[15:0]);
        check("n_recov", 16'(r.cfg.recovery_phase_len) + 16'h1, nr[15:0]);
        check("addr_seen", r.addr, got_addr);
        if (r.write) check("wr_seen", r.exp_data, got_wdata);
        else check("rdata", r.exp_data, rdata);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end

    initial begin
        // Last data column: write data seen by the peripheral, or read data
        rows[0] = {1'b1, 16'h1234, 16'hbeef, 16'hbeef,
            2'h0, 2'h0, 4'h1, 2'h0, 4'h0};
        rows[1] = {1'b0, 16'h8001, 16'h0000, 16'hbc3d,
            2'h3, 2'h3, 4'hf, 2'h3, 4'hf};
        rows[2] = {1'b1, 16'hffff, 16'h0000, 16'h0000,
            2'h1, 2'h2, 4'h0, 2'h3, 4'hf};
        rows[3] = {1'b0, 16'h0000, 16'h5a5a, 16'h3c3c,
            2'h2, 2'h1, 4'h0, 2'h1, 4'h0};
        rows[4] = {1'b1, 16'h00ff, 16'ha5c3, 16'ha5c3,
            2'h3, 2'h3, 4'hf, 2'h2, 4'h7};
        rows[5] = {1'b0, 16'hc0de, 16'h1111, 16'hfce2,
            2'h0, 2'h0, 4'h1, 2'h0, 4'h0};
        repeat (11) @(posedge clk);
        @(negedge clk);
        idle_chk();
        check("rdata_rst", 16'h0000, rdata);
        @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++) run(rows[i]);
        // Reset in mid-access must drop every pin to idle
        @(posedge clk);
        req <= {rows[1].write, rows[1].addr, rows[1].wdata};
        cfg <= rows[1].cfg;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        idle_chk();
        check("rdata_rst", 16'h0000, rdata);
        @(posedge clk);
        rstn <= 1'b1;
        run(rows[0]);
        close_out();
    end
endmodule
